// ### ecc_defines.vh
`ifndef ECC_DEFINES_VH
`define ECC_DEFINES_VH
// register byte addresses
`define ECC_ADDR_CTRL_A 12'h000
`define ECC_ADDR_CTRL_B 12'h004
`define ECC_ADDR_GAIN_A 12'h008
`define ECC_ADDR_GAIN_B 12'h00C
`define ECC_ADDR_STAT 12'h010
`define ECC_ADDR_TONE 12'h014
// control register fields
`define ECC_CB_CASCADE 0
`define ECC_CB_DUAL 1
`define ECC_CB_PAD12 2
`define ECC_CB_BYPASS 3
`define ECC_CB_FREEZE 4
`define ECC_CB_RXSIL 5
`define ECC_CB_TXSIL 6
`define ECC_CB_PHIGN 7
`define ECC_CB_AUTO 8
`define ECC_CB_NBOFF 9
`define ECC_CB_DCOFF 10
`define ECC_CB_RING 11
`define ECC_CB_CODE 12
`define ECC_CTRL_W 14
`define ECC_CTRL_RST 14'h0000
`define ECC_GAIN_RST 12'h000
// coding select
`define ECC_CODE_LIN 2'h0
`define ECC_CODE_SM 2'h1
`define ECC_CODE_MU 2'h2
`define ECC_CODE_A 2'h3
`define ECC_QUIET_LIN 16'h0000
`define ECC_QUIET_SM 16'h0080
`define ECC_QUIET_MU 16'h00FF
`define ECC_QUIET_A 16'h00D5
// timing
`define ECC_CLK_HZ 10000000
`define ECC_FRAME_HZ 8000
`define ECC_RELEASE_MS 400
`define ECC_FRAME_CYC (`ECC_CLK_HZ / `ECC_FRAME_HZ)
`define ECC_RELEASE_FRAMES (`ECC_RELEASE_MS * `ECC_FRAME_HZ / 1000)
// functional states, one-hot
`define ECC_ST_ADAPT 4'h1
`define ECC_ST_FROZEN 4'h2
`define ECC_ST_BYPASS 4'h4
`define ECC_ST_MUTE 4'h8
`endif

// ### ecc_tone_latch.v
`timescale 1ns/1ns
`default_nettype none
`include "ecc_defines.vh"
module ecc_tone_latch #(
  parameter RELEASE_FRAMES = `ECC_RELEASE_FRAMES
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire frame_tick,
  // detector evidence
  input wire tone_rx,
  input wire tone_tx,
  input wire quiet_rx,
  input wire quiet_tx,
  // status
  output reg flag,
  output reg set_pulse,
  output reg release_pulse
);
  reg [15:0] quiet_cnt;
  wire both_quiet = quiet_rx && quiet_tx;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
      quiet_cnt <= 16'h0000;
      set_pulse <= 1'b0;
      release_pulse <= 1'b0;
    end else begin
      set_pulse <= 1'b0;
      release_pulse <= 1'b0;
      if (!flag) begin
        quiet_cnt <= 16'h0000;
        if (tone_rx || tone_tx) begin
          flag <= 1'b1;
          set_pulse <= 1'b1;
        end
      end else if (!both_quiet) begin
        quiet_cnt <= 16'h0000;
      end else if (frame_tick) begin
        // count frame ticks while both stay quiet; release on the RELEASE_FRAMES-th tick
        if (quiet_cnt == RELEASE_FRAMES[15:0] - 16'h0001) begin
          flag <= 1'b0;
          release_pulse <= 1'b1;
          quiet_cnt <= 16'h0000;
        end else begin
          quiet_cnt <= quiet_cnt + 16'h0001;
        end
      end
    end
  end
endmodule // ecc_tone_latch
`default_nettype wire

// ### ecc_path.v
`timescale 1ns/1ns
`default_nettype none
`include "ecc_defines.vh"
module ecc_path (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // controls
  input wire [3:0] state,
  input wire [11:0] gains,
  input wire pad12,
  input wire rx_quiet_en,
  input wire tx_quiet_en,
  input wire [15:0] quiet,
  // samples
  input wire sample_en,
  input wire [15:0] rx_in,
  input wire [15:0] tx_in,
  output reg [15:0] rx_out,
  output reg [15:0] tx_out,
  output reg [15:0] rx_filt
);
  // gain code 0..7: +9 dB down to -12 dB in 3 dB steps, as shift of a 2^(1/2) scale
  function [15:0] scale;
    input [15:0] s;
    input [2:0] g;
    reg signed [15:0] v;
    reg signed [19:0] w;
    begin
      v = s;
      w = {{4{v[15]}}, v};
      case (g)
        3'h0: w = (w <<< 1) + (w >>> 1) + (w >>> 3);
        3'h1: w = (w <<< 1);
        3'h2: w = w + (w >>> 2) + (w >>> 3);
        3'h3: w = w;
        3'h4: w = (w >>> 1) + (w >>> 2);
        3'h5: w = (w >>> 1);
        3'h6: w = (w >>> 2) + (w >>> 3);
        default: w = (w >>> 2);
      endcase
      if (w > 20'sh07FFF) scale = 16'h7FFF;
      else if (w < -20'sh08000) scale = 16'h8000;
      else scale = w[15:0];
    end
  endfunction
  wire bypass = state == `ECC_ST_BYPASS;
  wire [15:0] rx_gain = pad12 ? scale(rx_in, 3'h7) : scale(rx_in, gains[2:0]);
  wire [15:0] rx_src = rx_quiet_en ? quiet : rx_gain;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out <= 16'h0000;
      tx_out <= 16'h0000;
      rx_filt <= 16'h0000;
    end else if (sample_en) begin
      if (bypass) begin
        rx_out <= rx_in;
        tx_out <= tx_in;
        rx_filt <= 16'h0000;
      end else begin
        rx_filt <= rx_src;
        rx_out <= rx_quiet_en ? quiet : scale(rx_src, gains[5:3]);
        tx_out <= tx_quiet_en ? quiet : scale(scale(tx_in, gains[8:6]), gains[11:9]);
      end
    end
  end
endmodule // ecc_path
`default_nettype wire

// ### ecc_channel.v
// Behaviour
// - tone seen on receive or send sets the tone flag and asserts interrupt low
// - tone flag stays set after the tone goes away
// - flag clears only after both inputs stay quiet for 400 ms
// - each flag release asserts the interrupt
// - phase-reversal-ignore selects criteria without phase reversal
// - automatic tone bypass lets detectors switch adaptation and bypass
// - ring suppress bit enables the instability detector
// - narrowband tones halt adaptation in the adaptation state unless disabled
// - dc null off bit bypasses offset filters on both inputs
// - four paths scale independently from +9 dB to -12 dB
// - legacy pad gives 12 dB receive loss in place of the receive input gain setting
// - dual direction bit in both cancellers gives back-to-back pairing
// - back-to-back uses one timeslot and zero code in b slot
// - cascade bit in a joins the pair; host keeps b bit 0 zero
// - cascaded tail sends quiet code in b slot
// - silence bits put quiet code on receive paths and send output unless bypass is active
// - quiet code follows the selected coding
// - back-to-back uses a silence bits on outputs; host keeps b bits zero
// - bypass passes codes unchanged and zeroes coefficients
// - frozen state holds coefficients while still cancelling
// - adaptation state updates coefficients continuously
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ecc_defines.vh"
module ecc_channel #(
  parameter RELEASE_FRAMES = `ECC_RELEASE_FRAMES,
  parameter FRAME_CYC = `ECC_FRAME_CYC
) (
  // clock and reset
  input wire MCLK,
  input wire RESETN,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output wire PSLVERR,
  // tone detector evidence, per canceller, a in bit 0
  input wire [1:0] TONE_REV_RX,
  input wire [1:0] TONE_REV_TX,
  input wire [1:0] TONE_PLAIN_RX,
  input wire [1:0] TONE_PLAIN_TX,
  input wire [1:0] QUIET_RX,
  input wire [1:0] QUIET_TX,
  input wire [1:0] NARROWBAND_SEEN,
  // samples, canceller a then b
  input wire SAMPLE_EN,
  input wire [31:0] RX_IN,
  input wire [31:0] TX_IN,
  output wire [31:0] RX_OUT,
  output wire [31:0] TX_OUT,
  output wire [31:0] RX_FILT,
  // filter engine controls
  output reg [1:0] COEFF_ADAPT,
  output reg [1:0] COEFF_CLEAR,
  output reg [1:0] RING_SUPPRESS_ON,
  output reg [1:0] DC_NULL_ON,
  output reg [1:0] CASCADE_ON,
  output reg [1:0] DUAL_ON,
  // interrupt
  output wire IRQ_N
);
  reg [`ECC_CTRL_W-1:0] ctrl [0:1];
  reg [11:0] gain [0:1];
  reg [1:0] tone_ev;
  reg [15:0] frame_cnt;
  reg frame_tick;
  wire [1:0] flag;
  wire [1:0] set_p;
  wire [1:0] rel_p;
  wire [3:0] st [0:1];
  wire [15:0] quiet [0:1];
  wire dual = ctrl[0][`ECC_CB_DUAL] && ctrl[1][`ECC_CB_DUAL];
  wire cascade = ctrl[0][`ECC_CB_CASCADE];
  wire wr = PSEL && PENABLE && PWRITE;
  // no wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;

  function [15:0] quiet_for;
    input [1:0] code;
    begin
      case (code)
        `ECC_CODE_LIN: quiet_for = `ECC_QUIET_LIN;
        `ECC_CODE_SM: quiet_for = `ECC_QUIET_SM;
        `ECC_CODE_MU: quiet_for = `ECC_QUIET_MU;
        default: quiet_for = `ECC_QUIET_A;
      endcase
    end
  endfunction

  function [3:0] decode_state;
    input [`ECC_CTRL_W-1:0] c;
    input tone;
    begin
      if (c[`ECC_CB_BYPASS] || (tone && c[`ECC_CB_AUTO])) decode_state = `ECC_ST_BYPASS;
      else if (c[`ECC_CB_RXSIL] || c[`ECC_CB_TXSIL]) decode_state = `ECC_ST_MUTE;
      else if (c[`ECC_CB_FREEZE]) decode_state = `ECC_ST_FROZEN;
      else decode_state = `ECC_ST_ADAPT;
    end
  endfunction

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      frame_cnt <= 16'h0000;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= 1'b0;
      if (frame_cnt == FRAME_CYC[15:0] - 16'h0001) begin
        frame_cnt <= 16'h0000;
        frame_tick <= 1'b1;
      end else begin
        frame_cnt <= frame_cnt + 16'h0001;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_can
      wire ign = ctrl[i][`ECC_CB_PHIGN];
      // ignore mode accepts either criteria, otherwise reversal is required
      wire t_rx = TONE_REV_RX[i] || (ign && TONE_PLAIN_RX[i]);
      wire t_tx = TONE_REV_TX[i] || (ign && TONE_PLAIN_TX[i]);
      ecc_tone_latch #(.RELEASE_FRAMES(RELEASE_FRAMES)) u_latch (
        .clk(MCLK),
        .rst_n(RESETN),
        .frame_tick(frame_tick),
        .tone_rx(t_rx),
        .tone_tx(t_tx),
        .quiet_rx(QUIET_RX[i]),
        .quiet_tx(QUIET_TX[i]),
        .flag(flag[i]),
        .set_pulse(set_p[i]),
        .release_pulse(rel_p[i])
      );
      assign st[i] = decode_state(ctrl[i], flag[i]);
      assign quiet[i] = quiet_for(ctrl[i][`ECC_CB_CODE+1:`ECC_CB_CODE]);
      // b slot in paired modes carries zero or quiet code; a silence bits steer outputs
      wire paired = dual || cascade;
      wire [3:0] st_eff = (i == 1 && paired) ? `ECC_ST_ADAPT : st[i];
      wire rxq = (i == 1 && paired) ? 1'b1 : ctrl[i][`ECC_CB_RXSIL];
      wire txq = (i == 1 && paired) ? 1'b1 : ctrl[i][`ECC_CB_TXSIL];
      wire [15:0] q = (i == 1 && dual) ? 16'h0000 : quiet[i];
      ecc_path u_path (
        .clk(MCLK),
        .rst_n(RESETN),
        .state(st_eff),
        .gains(gain[i]),
        .pad12(ctrl[i][`ECC_CB_PAD12]),
        .rx_quiet_en(rxq),
        .tx_quiet_en(txq),
        .quiet(q),
        .sample_en(SAMPLE_EN),
        .rx_in(RX_IN[16*i+15:16*i]),
        .tx_in(TX_IN[16*i+15:16*i]),
        .rx_out(RX_OUT[16*i+15:16*i]),
        .tx_out(TX_OUT[16*i+15:16*i]),
        .rx_filt(RX_FILT[16*i+15:16*i])
      );
      always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          COEFF_ADAPT[i] <= 1'b0;
          COEFF_CLEAR[i] <= 1'b0;
          RING_SUPPRESS_ON[i] <= 1'b0;
          DC_NULL_ON[i] <= 1'b0;
        end else begin
          // narrowband hold acts only in the adapt state; frozen keeps taps but cancels
          COEFF_ADAPT[i] <= (st[i] == `ECC_ST_ADAPT) &&
            !(NARROWBAND_SEEN[i] && !ctrl[i][`ECC_CB_NBOFF]);
          COEFF_CLEAR[i] <= st[i] == `ECC_ST_BYPASS;
          RING_SUPPRESS_ON[i] <= ctrl[i][`ECC_CB_RING];
          DC_NULL_ON[i] <= !ctrl[i][`ECC_CB_DCOFF];
        end
      end
      always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          ctrl[i] <= `ECC_CTRL_RST;
          gain[i] <= `ECC_GAIN_RST;
        end else if (wr) begin
          if (PADDR == (i == 0 ? `ECC_ADDR_CTRL_A : `ECC_ADDR_CTRL_B)) begin
            if (PSTRB[0]) ctrl[i][7:0] <= PWDATA[7:0];
            if (PSTRB[1]) ctrl[i][`ECC_CTRL_W-1:8] <= PWDATA[`ECC_CTRL_W-1:8];
          end
          if (PADDR == (i == 0 ? `ECC_ADDR_GAIN_A : `ECC_ADDR_GAIN_B)) begin
            if (PSTRB[0]) gain[i][7:0] <= PWDATA[7:0];
            if (PSTRB[1]) gain[i][11:8] <= PWDATA[11:8];
          end
        end
      end
    end
  endgenerate

  // sticky tone events; a new event in the clearing cycle wins
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tone_ev <= 2'b00;
      CASCADE_ON <= 2'b00;
      DUAL_ON <= 2'b00;
    end else begin
      if (wr && PADDR == `ECC_ADDR_TONE && PSTRB[0])
        tone_ev <= (tone_ev & ~PWDATA[1:0]) | set_p | rel_p;
      else
        tone_ev <= tone_ev | set_p | rel_p;
      CASCADE_ON <= {1'b0, cascade};
      DUAL_ON <= {dual, dual};
    end
  end
  assign IRQ_N = ~|tone_ev;

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `ECC_ADDR_CTRL_A: PRDATA <= {18'h0, ctrl[0]};
        `ECC_ADDR_CTRL_B: PRDATA <= {18'h0, ctrl[1]};
        `ECC_ADDR_GAIN_A: PRDATA <= {20'h0, gain[0]};
        `ECC_ADDR_GAIN_B: PRDATA <= {20'h0, gain[1]};
        `ECC_ADDR_STAT: PRDATA <= {20'h0, st[1], st[0], 2'h0, flag};
        `ECC_ADDR_TONE: PRDATA <= {30'h0, tone_ev};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
endmodule // ecc_channel
`default_nettype wire

// ### ecc_props.sv
`timescale 1ns/1ns
`default_nettype none
module ecc_props (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // samples
  input wire logic SAMPLE_EN,
  input wire logic [31:0] RX_IN,
  input wire logic [31:0] TX_IN,
  input wire logic [31:0] RX_OUT,
  input wire logic [31:0] TX_OUT,
  input wire logic [31:0] RX_FILT,
  // engine controls and interrupt
  input wire logic [1:0] COEFF_ADAPT,
  input wire logic [1:0] COEFF_CLEAR,
  input wire logic [1:0] DC_NULL_ON,
  input wire logic [1:0] CASCADE_ON,
  input wire logic [1:0] DUAL_ON,
  input wire logic IRQ_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire clr = PSEL && PENABLE && PWRITE && PADDR == 12'h014;
  wire single = DUAL_ON == 2'h0 && CASCADE_ON == 2'h0;
  a_apb_no_wait: assert property (PSEL |-> PREADY && !PSLVERR)
    else $error("apb slave stalled or flagged an error");
  a_irq_sticky: assert property (!IRQ_N && !clr |=> !IRQ_N)
    else $error("interrupt dropped without a clear");
  a_irq_clear_cause: assert property ($rose(IRQ_N) |-> $past(clr))
    else $error("interrupt released without a clear write");
  // clear flag lags the state by one edge, so it is read where the sample lands
  a_bypass_pass: assert property (single && SAMPLE_EN |=> !COEFF_CLEAR[0]
    || (RX_OUT[15:0] == $past(RX_IN[15:0]) && TX_OUT[15:0] == $past(TX_IN[15:0])
    && RX_FILT[15:0] == 16'h0000)) else $error("bypass altered the codes");
  a_clear_no_adapt: assert property ((COEFF_ADAPT & COEFF_CLEAR) == 2'h0)
    else $error("adapting while coefficients clear");
  a_dual_b_zero: assert property (SAMPLE_EN |=> DUAL_ON != 2'h3
    || (RX_OUT[31:16] == 16'h0000 && TX_OUT[31:16] == 16'h0000))
    else $error("second slot not zero in paired mode");
  a_dc_null_rst: assert property ($rose(RESETN) |=> DC_NULL_ON == 2'h3)
    else $error("offset filters off after reset");
  a_out_hold: assert property (!SAMPLE_EN |=> $stable(RX_OUT) && $stable(TX_OUT) && $stable(RX_FILT))
    else $error("outputs moved without a sample");
endmodule // ecc_props
bind ecc_channel ecc_props i_ecc_props (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SAMPLE_EN(SAMPLE_EN), .RX_IN(RX_IN), .TX_IN(TX_IN), .RX_OUT(RX_OUT), .TX_OUT(TX_OUT),
  .RX_FILT(RX_FILT), .COEFF_ADAPT(COEFF_ADAPT), .COEFF_CLEAR(COEFF_CLEAR),
  .DC_NULL_ON(DC_NULL_ON), .CASCADE_ON(CASCADE_ON), .DUAL_ON(DUAL_ON), .IRQ_N(IRQ_N));
`default_nettype wire

// ### ecc_tone_src.sv
`timescale 1ns/1ns
`default_nettype none
module ecc_tone_src (
  // clock
  input wire logic clk,
  // scenario
  input wire logic [1:0] tone,
  input wire logic rev,
  input wire logic [1:0] q_rx,
  input wire logic [1:0] q_tx,
  // detector evidence
  output logic [1:0] rev_rx,
  output logic [1:0] rev_tx,
  output logic [1:0] plain_rx,
  output logic [1:0] plain_tx,
  output logic [1:0] quiet_rx,
  output logic [1:0] quiet_tx
);
  always @(posedge clk) begin
    rev_rx <= tone & {2{rev}};
    rev_tx <= tone & {2{rev}};
    // a reversing tone meets the plain criteria as well
    plain_rx <= tone;
    plain_tx <= tone;
    quiet_rx <= q_rx;
    quiet_tx <= q_tx;
  end
endmodule // ecc_tone_src
`default_nettype wire

// ### ecc_channel_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ecc_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module ecc_channel_tb;
  localparam int RF = 4;
  localparam int FC = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sen = 1'b0, rev = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rxi = 32'h0, txi = 32'h0, rd;
  logic [1:0] tone = 2'h0, qrx = 2'h0, qtx = 2'h0, nb = 2'h0;
  logic [15:0] r1;
  logic [15:0] qc [4] = '{16'h0000, 16'h0080, 16'h00FF, 16'h00D5};
  logic [13:0] ct [6] = '{14'h000, 14'h010, 14'h008, 14'h038, 14'h030, 14'hC10};
  logic [3:0] st [6] = '{4'h1, 4'h2, 4'h4, 4'h4, 4'h8, 4'h2};
  wire [31:0] prdata, rxo, txo, rxf;
  wire pready, pslverr, irq_n;
  wire [1:0] trr, trt, tpr, tpt, qr, qt, adapt, clr, ring, dcn, casc, dual;
  int errors = 0, checks = 0;
  always #50 clk = ~clk;
  ecc_channel #(.RELEASE_FRAMES(RF), .FRAME_CYC(FC)) i_ecc_channel (.MCLK(clk), .RESETN(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .TONE_REV_RX(trr), .TONE_REV_TX(trt),
    .TONE_PLAIN_RX(tpr), .TONE_PLAIN_TX(tpt), .QUIET_RX(qr), .QUIET_TX(qt),
    .NARROWBAND_SEEN(nb), .SAMPLE_EN(sen), .RX_IN(rxi), .TX_IN(txi), .RX_OUT(rxo),
    .TX_OUT(txo), .RX_FILT(rxf), .COEFF_ADAPT(adapt), .COEFF_CLEAR(clr),
    .RING_SUPPRESS_ON(ring), .DC_NULL_ON(dcn), .CASCADE_ON(casc), .DUAL_ON(dual), .IRQ_N(irq_n));
  ecc_tone_src i_ecc_tone_src (.clk(clk), .tone(tone), .rev(rev), .q_rx(qrx), .q_tx(qtx),
    .rev_rx(trr), .rev_tx(trt), .plain_rx(tpr), .plain_tx(tpt), .quiet_rx(qr), .quiet_tx(qt));
  task automatic finish_test();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // request held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; paddr <= a; pwr <= w; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic smp(input logic [31:0] r, input logic [31:0] t);
    @(posedge clk);
    rxi <= r; txi <= t; sen <= 1'b1;
    @(posedge clk);
    sen <= 1'b0;
    cyc(1);
  endtask
  initial begin
    #(100 * 30000);
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctrl_a", `ECC_ADDR_CTRL_A, 32'h0);
    rchk("gain_a", `ECC_ADDR_GAIN_A, 32'h0);
    rchk("status", `ECC_ADDR_STAT, 32'h110);
    `CHK("dc_null_rst", 2'h3, dcn)
    `CHK("ring_rst", 2'h0, ring)
    apb(12'h018, 1'b1, 32'hFFFFFFFF);
    rchk("unmapped", 12'h018, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(`ECC_ADDR_CTRL_A, 1'b1, {18'h0, ct[i]});
      cyc(2);
      rchk("state", `ECC_ADDR_STAT, {20'h0, 4'h1, st[i], 4'h0});
      `CHK("ring", ct[i][11], ring[0])
      `CHK("dc_null", ~ct[i][10], dcn[0])
      if (st[i] != 4'h8) begin
        `CHK("adapt", st[i] == 4'h1, adapt[0])
        `CHK("clear", st[i] == 4'h4, clr[0])
      end
    end
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h0);
    @(posedge clk) nb <= 2'h1;
    cyc(3);
    `CHK("nb_halt", 1'b0, adapt[0])
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h200);
    cyc(3);
    `CHK("nb_off", 1'b1, adapt[0])
    @(posedge clk) nb <= 2'h0;
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'h6DB);
    for (int c = 0; c < 4; c++) begin
      apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h60 | (c << 12));
      cyc(2);
      smp(32'h12345678, 32'h13572468);
      `CHK("rx_quiet", qc[c], rxo[15:0])
      `CHK("filt_quiet", qc[c], rxf[15:0])
      `CHK("tx_quiet", qc[c], txo[15:0])
    end
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h0);
    smp(32'h4000, 32'h0);
    `CHK("unity", 16'h4000, rxo[15:0])
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'h6DF);
    smp(32'h4000, 32'h0);
    r1 = rxo[15:0];
    `CHK("loss", 1'b1, r1 < 16'h4000)
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'h6FB);
    smp(32'h4000, 32'h0);
    `CHK("rx_out_pad", r1, rxo[15:0])
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'h6D8);
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h4);
    smp(32'h4000, 32'h0);
    `CHK("pad12", r1, rxo[15:0])
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'hFFF);
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h8);
    cyc(2);
    smp(32'h7ABC, 32'h9DEF);
    `CHK("byp_rx", 16'h7ABC, rxo[15:0])
    `CHK("byp_tx", 16'h9DEF, txo[15:0])
    `CHK("byp_filt", 16'h0000, rxf[15:0])
    apb(`ECC_ADDR_GAIN_A, 1'b1, 32'h6DB);
    apb(`ECC_ADDR_CTRL_B, 1'b1, 32'h2);
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h2062);
    cyc(2);
    `CHK("dual", 2'h3, dual)
    smp(32'h55551111, 32'h66662222);
    `CHK("dual_rx", 32'h000000FF, rxo)
    `CHK("dual_tx", 32'h000000FF, txo)
    apb(`ECC_ADDR_CTRL_B, 1'b1, 32'h3000);
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h3001);
    cyc(2);
    `CHK("cascade", 2'h1, casc)
    smp(32'h55551111, 32'h66662222);
    `CHK("casc_rx", 16'h00D5, rxo[31:16])
    `CHK("casc_tx", 16'h00D5, txo[31:16])
    apb(`ECC_ADDR_CTRL_A, 1'b1, 32'h100);
    apb(`ECC_ADDR_CTRL_B, 1'b1, 32'h80);
    apb(`ECC_ADDR_TONE, 1'b1, 32'h3);
    @(posedge clk) tone <= 2'h3;
    cyc(3);
    rchk("plain_tone", `ECC_ADDR_STAT, 32'h112);
    `CHK("irq_set", 1'b0, irq_n)
    @(posedge clk) rev <= 1'b1;
    cyc(3);
    rchk("rev_tone", `ECC_ADDR_STAT, 32'h143);
    apb(`ECC_ADDR_CTRL_B, 1'b1, 32'h88);
    cyc(FC);
    @(posedge clk) tone <= 2'h0;
    apb(`ECC_ADDR_TONE, 1'b1, 32'h3);
    cyc(1);
    `CHK("irq_clr", 1'b1, irq_n)
    @(posedge clk) qrx <= 2'h3;
    cyc(8 * FC);
    rchk("one_quiet", `ECC_ADDR_STAT, 32'h443);
    `CHK("irq_hold", 1'b1, irq_n)
    `CHK("clear_both", 2'h3, clr)
    `CHK("adapt_none", 2'h0, adapt)
    @(posedge clk) qtx <= 2'h3;
    cyc(2 * FC);
    rchk("early", `ECC_ADDR_STAT, 32'h443);
    cyc((RF + 1) * FC);
    rchk("release", `ECC_ADDR_STAT, 32'h410);
    `CHK("irq_rel", 1'b0, irq_n)
    `CHK("adapt_back", 2'h1, adapt)
    rchk("events", `ECC_ADDR_TONE, 32'h3);
    finish_test();
  end
endmodule // ecc_channel_tb
`default_nettype wire
